/* pkg/iacc_pkg.sv */
// Package for the integer ALU slice: opcodes, sizes, access types.
`default_nettype none
package iacc_pkg;
  // Operand sizes: byte, word, longword, quadword
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2,
    SZ_QUAD = 2'h3
  } iacc_size_type;

  // Access-type letters of an operand specifier
  typedef enum logic [2:0] {
    ACC_ADDRESS = 3'h0,
    ACC_BRANCH = 3'h1,
    ACC_MODIFY = 3'h2,
    ACC_READ = 3'h3,
    ACC_FIELD_BASE = 3'h4,
    ACC_WRITE = 3'h5
  } iacc_access_type;

  // Data-type letters of an operand specifier
  typedef enum logic [3:0] {
    DT_BYTE = 4'h0,
    DT_WORD = 4'h1,
    DT_LONG = 4'h2,
    DT_QUAD = 4'h3,
    DT_FIELD = 4'h4,
    DT_MULTI = 4'h5,
    DT_FFLOAT = 4'h6,
    DT_DFLOAT = 4'h7,
    DT_GFLOAT = 4'h8
  } iacc_dtype_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DIV = 2'h1,
    ST_DONE = 2'h2
  } iacc_state_type;

  localparam logic [7:0] OP_ADD_B3 = 8'h81;
  localparam logic [7:0] OP_ADD_L3 = 8'hC1;
  localparam logic [7:0] OP_ADD_W3 = 8'hA1;
  localparam logic [7:0] OP_BIC_B3 = 8'h8B;
  localparam logic [7:0] OP_BIC_L3 = 8'hCB;
  localparam logic [7:0] OP_BIC_W3 = 8'hAB;
  localparam logic [7:0] OP_BIS_B3 = 8'h89;
  localparam logic [7:0] OP_BIS_L3 = 8'hC9;
  localparam logic [7:0] OP_BIS_W3 = 8'hA9;
  localparam logic [7:0] OP_CMP_B = 8'h91;
  localparam logic [7:0] OP_CMP_L = 8'hD1;
  localparam logic [7:0] OP_CMP_W = 8'hB1;
  localparam logic [7:0] OP_ASH_L = 8'h78;
  localparam logic [7:0] OP_ASH_Q = 8'h79;
  localparam logic [7:0] OP_CVT_BL = 8'h98;
  localparam logic [7:0] OP_CVT_BW = 8'h99;
  localparam logic [7:0] OP_CVT_LB = 8'hF6;
  localparam logic [7:0] OP_CVT_LW = 8'hF7;
  localparam logic [7:0] OP_CVT_WB = 8'h33;
  localparam logic [7:0] OP_CVT_WL = 8'h32;
  localparam logic [7:0] OP_DIV_L2 = 8'hC6;
  localparam logic [7:0] OP_DIV_B2 = 8'h86;
  localparam logic [7:0] OP_DIV_W2 = 8'hA6;
  localparam logic [7:0] OP_EXTENDED_MULTIPLY = 8'h7A;
  localparam logic [7:0] OP_CLR_B = 8'h94;
  localparam logic [7:0] OP_CLR_L = 8'hD4;
  localparam logic [7:0] OP_CLR_Q = 8'h7C;
  localparam logic [7:0] OP_CLR_W = 8'hB4;

  // Divide runs one quotient bit per clock over 32 bits
  localparam logic [5:0] DIV_STEPS = 6'h20;
  localparam logic [63:0] RESET_RESULT = 64'h0;
endpackage
`default_nettype wire

/* core/iacc_alu.sv */
// Integer ALU execution slice with condition codes and traps.
//
// Summary of operation
// - Three-operand add writes sum, sets NZVC, traps on signed overflow.
// - Bit-clear writes source and not mask, sets NZ, clears V, keeps C.
// - Bit-set writes source or mask, sets NZ, clears V, keeps C.
// - Compare writes nothing, sets N Z C from sources, clears V.
// - Longword arithmetic shift sets NZV, clears C, traps on lost bits.
// - Quadword arithmetic shift sets NZV, clears C, traps on overflow.
// - Widening converts clear V and C; narrowing clears C, sets V and traps when the value does not fit.
// - Divide traps on zero divisor and quotient overflow, clears C.
// - Extended multiply plus addend gives quadword, sets NZ, clears V.
// - Clear opcodes write zero to byte, long, quad or word destination.
// - Access-type letter decides which operands are fetched and stored.
// - Modified operand is read, then written back to same place.
// - Data-type letter selects operand size.
// - Implied operands are accessed by the execution sequence itself.
`default_nettype none
module iacc_alu
  import iacc_pkg::*;
(
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  // Request from decode
  input wire logic I_START,
  input wire logic [7:0] I_OPCODE,
  input wire logic [63:0] I_SRC1,
  input wire logic [63:0] I_SRC2,
  input wire logic [31:0] I_SRC3,
  input wire logic [3:0] I_DST_DTYPE,
  input wire logic [2:0] I_DST_ACCESS,
  input wire logic I_CC_C,
  // Result
  output logic O_BUSY,
  output logic O_DONE,
  output logic [63:0] O_RESULT,
  output logic O_WRITE_DST,
  output logic O_WRITE_BACK,
  output logic O_NEED_FETCH,
  output logic [1:0] O_DST_SIZE,
  output logic [3:0] O_NZVC,
  output logic O_TRAP_IOV,
  output logic O_TRAP_IDVZ
);

  iacc_state_type state;
  logic [63:0] r;
  logic n, z, v, c, wr, iov, known;
  logic [1:0] sz;
  logic [5:0] div_cnt;
  logic [31:0] div_rem, div_quo, div_dvr;
  logic div_neg;
  logic [1:0] div_sz;

  // Sign extend a value of the given size to 64 bits
  function automatic logic [63:0] sext(input logic [63:0] x,
                                        input logic [1:0] s);
    case (s)
      SZ_BYTE: sext = {{56{x[7]}}, x[7:0]};
      SZ_WORD: sext = {{48{x[15]}}, x[15:0]};
      SZ_LONG: sext = {{32{x[31]}}, x[31:0]};
      default: sext = x;
    endcase
  endfunction

  // ===================================================================
  // Operand size from opcode group
  // ===================================================================
  // widths by opcode column
  function automatic logic [1:0] op_size(input logic [7:0] op);
    if (op == OP_ASH_Q || op == OP_EXTENDED_MULTIPLY || op == OP_CLR_Q)
      op_size = SZ_QUAD;
    else if (op[7:4] == 4'h8 || op[7:4] == 4'h9)
      op_size = SZ_BYTE;
    else if (op[7:4] == 4'hA || op[7:4] == 4'hB)
      op_size = SZ_WORD;
    else
      op_size = SZ_LONG;
  endfunction

  always_comb begin
    case (I_DST_DTYPE)
      DT_BYTE: O_DST_SIZE = SZ_BYTE;
      DT_WORD: O_DST_SIZE = SZ_WORD;
      DT_QUAD, DT_DFLOAT, DT_GFLOAT: O_DST_SIZE = SZ_QUAD;
      default: O_DST_SIZE = SZ_LONG;
    endcase
  end

  // fetch only for read or modified; store whenever the operation writes, whatever the access type
  assign O_NEED_FETCH = (I_DST_ACCESS == ACC_MODIFY) ||
                        (I_DST_ACCESS == ACC_READ);

  // ===================================================================
  // Single-cycle datapath
  // ===================================================================
  logic [63:0] a, b, sh, prod, sa;
  logic signed [7:0] cnt;
  logic [6:0] ucnt;

  always_comb begin
    sz = op_size(I_OPCODE);
    a = sext(I_SRC1, sz);
    b = sext(I_SRC2, sz);
    r = 64'h0;
    n = 1'b0;
    z = 1'b0;
    v = 1'b0;
    c = I_CC_C;
    wr = 1'b1;
    iov = 1'b0;
    known = 1'b1;
    sh = 64'h0;
    prod = 64'h0;
    cnt = I_SRC1[7:0];
    ucnt = 7'h0;
    sa = 64'h0;
    case (I_OPCODE)
      OP_ADD_B3, OP_ADD_W3, OP_ADD_L3: begin
        r = sext(a + b, sz);
        v = (a[63] == b[63]) && (r[63] != a[63]);
        case (sz)
          SZ_BYTE: c = ({1'b0, I_SRC1[7:0]} + {1'b0, I_SRC2[7:0]}) > 9'h0FF;
          SZ_WORD:
            c = ({1'b0, I_SRC1[15:0]} + {1'b0, I_SRC2[15:0]}) > 17'h0FFFF;
          default:
            c = ({1'b0, I_SRC1[31:0]} + {1'b0, I_SRC2[31:0]}) >
                33'h0FFFFFFFF;
        endcase
        iov = v;
      end
      OP_BIC_B3, OP_BIC_W3, OP_BIC_L3: r = sext(I_SRC2 & ~I_SRC1, sz);
      OP_BIS_B3, OP_BIS_W3, OP_BIS_L3: r = sext(I_SRC2 | I_SRC1, sz);
      OP_CMP_B, OP_CMP_W, OP_CMP_L: begin
        wr = 1'b0;
        r = a - b;
        case (sz)
          SZ_BYTE: c = I_SRC1[7:0] < I_SRC2[7:0];
          SZ_WORD: c = I_SRC1[15:0] < I_SRC2[15:0];
          default: c = I_SRC1[31:0] < I_SRC2[31:0];
        endcase
      end
      // arithmetic shift, positive count is left
      OP_ASH_L, OP_ASH_Q: begin
        sa = (I_OPCODE == OP_ASH_L) ? sext(I_SRC2, SZ_LONG) : I_SRC2;
        if (cnt >= 0) begin
          ucnt = (cnt > 8'sh3F) ? 7'h40 : cnt[6:0];
          sh = (ucnt[6]) ? 64'h0 : sa << ucnt[5:0];
          r = (I_OPCODE == OP_ASH_L) ? sext(sh, SZ_LONG) : sh;
          // Lost bits: shifting back must restore the source
          v = (ucnt[6]) ? (sa != 64'h0) :
              (($signed(r) >>> ucnt[5:0]) != $signed(sa)) ||
              ((I_OPCODE == OP_ASH_L) && (sh != r));
        end else begin
          ucnt = (cnt < -8'sh3F) ? 7'h3F : 7'(-cnt);
          r = 64'($signed(sa) >>> ucnt[5:0]);
        end
        c = 1'b0;
        iov = v;
      end
      OP_CVT_BL, OP_CVT_BW, OP_CVT_WL: begin
        r = sext(I_SRC1, (I_OPCODE == OP_CVT_WL) ? SZ_WORD : SZ_BYTE);
        c = 1'b0;
      end
      OP_CVT_LB, OP_CVT_LW, OP_CVT_WB: begin
        a = sext(I_SRC1, (I_OPCODE == OP_CVT_WB) ? SZ_WORD : SZ_LONG);
        r = sext(a, (I_OPCODE == OP_CVT_LW) ? SZ_WORD : SZ_BYTE);
        v = r != a;
        c = 1'b0;
        iov = v;
      end
      OP_EXTENDED_MULTIPLY: begin
        prod = 64'($signed(sext(I_SRC1, SZ_LONG)) *
                   $signed(sext(I_SRC2, SZ_LONG)));
        r = prod + sext({32'h0, I_SRC3}, SZ_LONG);
        c = 1'b0;
      end
      OP_CLR_B, OP_CLR_W, OP_CLR_L, OP_CLR_Q: r = 64'h0;
      default: begin
        known = 1'b0;
        wr = 1'b0;
      end
    endcase
    // Sign-extended operands: a compare difference cannot wrap
    n = r[63];
    z = r == 64'h0;
  end

  wire is_div = (I_OPCODE == OP_DIV_B2) || (I_OPCODE == OP_DIV_W2) ||
                (I_OPCODE == OP_DIV_L2);
  wire [63:0] dvr_s = sext(I_SRC1, sz);
  wire [63:0] dvd_s = sext(I_SRC2, sz);

  // ===================================================================
  // Control and divider
  // ===================================================================
  wire [31:0] next_rem_try = {div_rem[30:0], div_quo[31]} - div_dvr;
  wire div_fits = !({div_rem[30:0], div_quo[31]} < div_dvr);

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state <= ST_IDLE;
      div_cnt <= 6'h0;
      div_rem <= 32'h0;
      div_quo <= 32'h0;
      div_dvr <= 32'h0;
      div_neg <= 1'b0;
      div_sz <= SZ_BYTE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (I_START && is_div && dvr_s != 64'h0) begin
            state <= ST_DIV;
            div_cnt <= DIV_STEPS;
            div_rem <= 32'h0;
            div_quo <= dvd_s[63] ? 32'(-dvd_s) : dvd_s[31:0];
            div_dvr <= dvr_s[63] ? 32'(-dvr_s) : dvr_s[31:0];
            div_neg <= dvd_s[63] ^ dvr_s[63];
            div_sz <= sz;
          end
        end
        ST_DIV: begin
          div_cnt <= div_cnt - 6'h1;
          div_quo <= {div_quo[30:0], div_fits};
          div_rem <= div_fits ? next_rem_try :
                     {div_rem[30:0], div_quo[31]};
          if (div_cnt == 6'h1)
            state <= ST_DONE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Quotient out of range for the operand size is overflow
  wire [63:0] quo_s = div_neg ? 64'(-{32'h0, div_quo}) : {32'h0, div_quo};
  wire quo_ovf = sext(quo_s, div_sz) != quo_s;

  // ===================================================================
  // Registered outputs
  // ===================================================================
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_DONE <= 1'b0;
      O_RESULT <= RESET_RESULT;
      O_WRITE_DST <= 1'b0;
      O_WRITE_BACK <= 1'b0;
      O_NZVC <= 4'h0;
      O_TRAP_IOV <= 1'b0;
      O_TRAP_IDVZ <= 1'b0;
    end else begin
      O_DONE <= 1'b0;
      O_TRAP_IOV <= 1'b0;
      O_TRAP_IDVZ <= 1'b0;
      O_WRITE_DST <= 1'b0;
      O_WRITE_BACK <= 1'b0;
      if (state == ST_IDLE && I_START && is_div && dvr_s == 64'h0) begin
        // zero divisor, destination unchanged, V set, C clear
        O_DONE <= 1'b1;
        O_TRAP_IDVZ <= 1'b1;
        O_NZVC <= {dvd_s[63], dvd_s == 64'h0, 1'b1, 1'b0};
      end else if (state == ST_IDLE && I_START && !is_div && known) begin
        O_DONE <= 1'b1;
        O_RESULT <= r;
        O_NZVC <= {n, z, v, c};
        O_TRAP_IOV <= iov;
        // modified operand is written back in place
        O_WRITE_DST <= wr && known;
        O_WRITE_BACK <= wr && known && (I_DST_ACCESS == ACC_MODIFY);
      end else if (state == ST_DONE) begin
        // quotient overflow traps, C always clear
        O_DONE <= 1'b1;
        O_RESULT <= sext(quo_s, div_sz);
        O_NZVC <= {quo_s[63] && !quo_ovf, quo_s == 64'h0, quo_ovf, 1'b0};
        O_TRAP_IOV <= quo_ovf;
        // divide two-operand form rewrites its modified quotient
        O_WRITE_DST <= !quo_ovf;
        O_WRITE_BACK <= !quo_ovf;
      end
    end
  end

  assign O_BUSY = state != ST_IDLE;

  // ===================================================================
  // Checks
  // ===================================================================
  wire op_add = (I_OPCODE == OP_ADD_B3) || (I_OPCODE == OP_ADD_W3) ||
                (I_OPCODE == OP_ADD_L3);
  wire op_cmp = (I_OPCODE == OP_CMP_B) || (I_OPCODE == OP_CMP_W) ||
                (I_OPCODE == OP_CMP_L);
  wire op_bit = (I_OPCODE == OP_BIC_B3) || (I_OPCODE == OP_BIS_B3) ||
                (I_OPCODE == OP_BIC_L3) || (I_OPCODE == OP_BIS_L3);
  wire go = !O_BUSY && I_START;

  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);

  sequence div_go_s;
    go && is_div && (dvr_s != 64'h0);
  endsequence

  add_trap_a: assert property (go && op_add |=>
    O_TRAP_IOV == O_NZVC[1]) else $error("add trap mismatch");
  bit_keep_c_a: assert property (go && op_bit |=>
    O_NZVC[0] == $past(I_CC_C) && !O_NZVC[1])
    else $error("bit op changed C or V");
  cmp_nowrite_a: assert property (go && op_cmp |=>
    O_DONE && !O_WRITE_DST && !O_NZVC[1]) else $error("compare wrote");
  shift_c_a: assert property (go && (I_OPCODE == OP_ASH_L) |=>
    !O_NZVC[0] && O_TRAP_IOV == O_NZVC[1]) else $error("shift flags");
  cvt_wide_a: assert property (go && (I_OPCODE == OP_CVT_BL) |=>
    O_NZVC[1:0] == 2'h0 && !O_TRAP_IOV) else $error("widen flags");
  div_zero_a: assert property (go && is_div && dvr_s == 64'h0 |=>
    O_TRAP_IDVZ && O_DONE && !O_WRITE_DST) else $error("div zero");
  div_len_a: assert property (div_go_s |->
    ##34 (O_DONE && !O_NZVC[0])) else $error("divide length");
  extended_multiply_v_a: assert property (go && (I_OPCODE == OP_EXTENDED_MULTIPLY) |=>
    !O_NZVC[1] && !O_TRAP_IOV) else $error("multiply V");
  clr_zero_a: assert property (go && (I_OPCODE == OP_CLR_Q) |=>
    O_RESULT == 64'h0 && O_NZVC[2]) else $error("clear result");
  modify_wb_a: assert property (go && op_add &&
    I_DST_ACCESS == ACC_MODIFY |=> O_WRITE_BACK)
    else $error("write back");
endmodule
`default_nettype wire

/* dv/iacc_decode_model.sv */
// Decode-side model that issues operations to the integer ALU slice.
`default_nettype none
module iacc_decode_model
  import iacc_pkg::*;
(
  // Clock and handshake
  input wire logic i_clk,
  input wire logic i_done,
  // Request to the slice
  output logic o_start,
  output logic [7:0] o_opcode,
  output logic [63:0] o_src1,
  output logic [63:0] o_src2,
  output logic [31:0] o_src3,
  output logic o_cc_c,
  // Specifier decode
  output logic [3:0] o_dtype,
  output logic [2:0] o_access
);
  // ==========================================
  // Idle values
  initial begin
    o_start = 1'b0;
    o_opcode = 8'h00;
    o_src1 = 64'h0;
    o_src2 = 64'h0;
    o_src3 = 32'h0;
    o_cc_c = 1'b0;
    o_dtype = DT_LONG;
    o_access = ACC_WRITE;
  end

  // ==========================================
  // Requests
  // specifier letters
  task automatic set_spec(input logic [2:0] acc, input logic [3:0] dt);
    o_access = acc;
    o_dtype = dt;
  endtask

  // Operands stay put until the next request, as decode would hold them
  task automatic issue(input logic [7:0] op, input logic [63:0] a,
      input logic [63:0] b, input logic [31:0] c, input logic cc,
      output int lat);
    @(negedge i_clk);
    o_opcode = op;
    o_src1 = a;
    o_src2 = b;
    o_src3 = c;
    o_cc_c = cc;
    o_start = 1'b1;
    @(negedge i_clk);
    o_start = 1'b0;
    lat = 1;
    while (i_done !== 1'b1 && lat < 60) begin
      @(negedge i_clk);
      lat++;
    end
  endtask
endmodule
`default_nettype wire

/* dv/iacc_alu_tb.sv */
// Self-checking bench for the integer ALU slice.
`default_nettype none
module iacc_alu_tb
  import iacc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, start, cc_c, done, busy, wr_dst, wr_back, fetch;
  logic iov, idvz;
  logic [7:0] opcode;
  logic [63:0] src1, src2, result;
  logic [31:0] src3;
  logic [3:0] dtype, nzvc;
  logic [2:0] access, acc_v;
  logic [1:0] dsize;
  int mismatches, n_compared, lat;

  iacc_alu dut_u (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_START(start),
    .I_OPCODE(opcode), .I_SRC1(src1), .I_SRC2(src2), .I_SRC3(src3),
    .I_DST_DTYPE(dtype), .I_DST_ACCESS(access), .I_CC_C(cc_c),
    .O_BUSY(busy), .O_DONE(done), .O_RESULT(result), .O_WRITE_DST(wr_dst),
    .O_WRITE_BACK(wr_back), .O_NEED_FETCH(fetch), .O_DST_SIZE(dsize),
    .O_NZVC(nzvc), .O_TRAP_IOV(iov), .O_TRAP_IDVZ(idvz));
  iacc_decode_model dec_u (.i_clk(clk), .i_done(done), .o_start(start),
    .o_opcode(opcode), .o_src1(src1), .o_src2(src2), .o_src3(src3),
    .o_cc_c(cc_c), .o_dtype(dtype), .o_access(access));

  // ==========================================
  // Clock and compares
  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic chk_data(string nm, logic [63:0] e, logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_cc(string nm, logic [3:0] e, logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(string nm, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask

  // Result is only judged when something is stored
  task automatic op_check(logic [7:0] op, logic [3:0] dt, logic [63:0] a,
      logic [63:0] b, logic [31:0] c, logic cc, logic [63:0] er,
      logic [3:0] en, logic ei, logic ew);
    dec_u.set_spec(acc_v, dt);
    dec_u.issue(op, a, b, c, cc, lat);
    chk_bit("done", 1'b1, done);
    if (ew) chk_data("result", er, result);
    chk_cc("nzvc", en, nzvc);
    chk_bit("iov", ei, iov);
    chk_bit("store", ew, wr_dst | wr_back);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_add;
    op_check(OP_ADD_L3, DT_LONG, 64'h7FFFFFFF, 64'h1, 32'h0, 1'b0,
      64'hFFFFFFFF80000000, 4'hA, 1'b1, 1'b1);
    op_check(OP_ADD_B3, DT_BYTE, 64'hFF, 64'h1, 32'h0, 1'b0,
      64'h0, 4'h5, 1'b0, 1'b1);
    op_check(OP_ADD_W3, DT_WORD, 64'h7FFF, 64'h7FFF, 32'h0, 1'b0,
      64'hFFFFFFFFFFFFFFFE, 4'hA, 1'b1, 1'b1);
  endtask
  task automatic t_logic;
    op_check(OP_BIC_L3, DT_LONG, 64'hF0, 64'hFF, 32'h0, 1'b1,
      64'h0F, 4'h1, 1'b0, 1'b1);
    op_check(OP_BIS_L3, DT_LONG, 64'h80000000, 64'h1, 32'h0, 1'b0,
      64'hFFFFFFFF80000001, 4'h8, 1'b0, 1'b1);
    op_check(OP_BIC_B3, DT_BYTE, 64'hFF, 64'hFF, 32'h0, 1'b0,
      64'h0, 4'h4, 1'b0, 1'b1);
  endtask
  task automatic t_compare;
    op_check(OP_CMP_B, DT_BYTE, 64'h1, 64'h2, 32'h0, 1'b0,
      64'h0, 4'h9, 1'b0, 1'b0);
    op_check(OP_CMP_L, DT_LONG, 64'h80000000, 64'h1, 32'h0, 1'b1,
      64'h0, 4'h8, 1'b0, 1'b0);
    op_check(OP_CMP_W, DT_WORD, 64'h1234, 64'h1234, 32'h0, 1'b0,
      64'h0, 4'h4, 1'b0, 1'b0);
  endtask
  task automatic t_shift;
    op_check(OP_ASH_L, DT_LONG, 64'h1, 64'h40000000, 32'h0, 1'b1,
      64'hFFFFFFFF80000000, 4'hA, 1'b1, 1'b1);
    op_check(OP_ASH_Q, DT_QUAD, 64'hFF, 64'h8000000000000000, 32'h0,
      1'b1, 64'hC000000000000000, 4'h8, 1'b0, 1'b1);
  endtask
  task automatic t_convert;
    op_check(OP_CVT_BL, DT_LONG, 64'hFF, 64'hFF, 32'h0, 1'b1,
      64'hFFFFFFFFFFFFFFFF, 4'h8, 1'b0, 1'b1);
    op_check(OP_CVT_LB, DT_BYTE, 64'h100, 64'h100, 32'h0, 1'b0,
      64'h0, 4'h6, 1'b1, 1'b1);
    op_check(OP_CVT_WL, DT_LONG, 64'h8000, 64'h8000, 32'h0, 1'b1,
      64'hFFFFFFFFFFFF8000, 4'h8, 1'b0, 1'b1);
  endtask
  task automatic t_divide;
    acc_v = ACC_MODIFY;
    op_check(OP_DIV_L2, DT_LONG, 64'h2, 64'h7, 32'h0, 1'b1,
      64'h3, 4'h0, 1'b0, 1'b1);
    chk_data("latency", 64'h22, 64'(lat));
    chk_bit("writeback", 1'b1, wr_back);
    op_check(OP_DIV_L2, DT_LONG, 64'h0, 64'h7, 32'h0, 1'b1,
      64'h0, 4'h2, 1'b0, 1'b0);
    chk_bit("idvz", 1'b1, idvz);
    dec_u.issue(OP_DIV_B2, 64'hFF, 64'h80, 32'h0, 1'b1, lat);
    chk_bit("iov", 1'b1, iov);
    chk_bit("ovf_v", 1'b1, nzvc[1]);
    acc_v = ACC_WRITE;
  endtask
  task automatic t_extended_multiply;
    op_check(OP_EXTENDED_MULTIPLY, DT_QUAD, 64'h10000, 64'h10000, 32'h5, 1'b0,
      64'h0000000100000005, 4'h0, 1'b0, 1'b1);
    op_check(OP_EXTENDED_MULTIPLY, DT_QUAD, 64'hFFFFFFFFFFFFFFFF, 64'h2, 32'h0,
      1'b0, 64'hFFFFFFFFFFFFFFFE, 4'h8, 1'b0, 1'b1);
  endtask
  task automatic t_clear;
    logic [7:0] ops [4] = '{OP_CLR_B, OP_CLR_L, OP_CLR_Q, OP_CLR_W};
    logic [3:0] dts [4] = '{DT_BYTE, DT_LONG, DT_QUAD, DT_WORD};
    for (int i = 0; i < 4; i++) begin
      op_check(ops[i], dts[i], 64'h5A, 64'hA5, 32'h0, 1'b1,
        64'h0, 4'h5, 1'b0, 1'b1);
    end
  endtask
  task automatic t_abort;
    dec_u.set_spec(ACC_MODIFY, DT_LONG);
    fork
      dec_u.issue(OP_DIV_L2, 64'h3, 64'h9, 32'h0, 1'b0, lat);
    join_none
    repeat (3) @(negedge clk);
    chk_bit("busy", 1'b1, busy);
    rst_n = 1'b0;
    @(negedge clk);
    chk_bit("busy_reset", 1'b0, busy);
    chk_cc("nzvc_reset", 4'h0, nzvc);
    rst_n = 1'b1;
    wait fork;
    acc_v = ACC_MODIFY;
    op_check(OP_ADD_L3, DT_LONG, 64'h1, 64'h2, 32'h0, 1'b0,
      64'h3, 4'h0, 1'b0, 1'b1);
    chk_bit("writeback_add", 1'b1, wr_back);
    acc_v = ACC_WRITE;
  endtask
  task automatic t_decode;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      dec_u.set_spec(3'(i), DT_LONG);
      #1;
      chk_bit("fetch", i == ACC_READ || i == ACC_MODIFY, fetch);
    end
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      dec_u.set_spec(ACC_WRITE, 4'(i));
      #1;
      chk_data("size", 64'(i), 64'(dsize));
    end
  endtask

  // ==========================================
  // Run control
  task automatic tally_and_finish;
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // About 190 cycles of traffic; sixteen-fold margin
  initial begin
    #60000;
    mismatches++;
    tally_and_finish;
  end

  initial begin
    rst_n = 1'b0;
    acc_v = ACC_WRITE;
    mismatches = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_data("reset_result", 64'h0, result);
    chk_cc("reset_nzvc", 4'h0, nzvc);
    rst_n = 1'b1;
    t_decode;
    t_add;
    t_logic;
    t_compare;
    t_shift;
    t_convert;
    t_divide;
    t_extended_multiply;
    t_clear;
    t_abort;
    tally_and_finish;
  end
endmodule
`default_nettype wire
